// ==== hw/oled_cmd_pkg.sv ====
// Purpose: Shared constants for the serial command port of the display controller.
// Assumes: Eight-bit serial bytes, most significant bit first.
// Notes:   Command codes, reset values and field positions live here.
package oled_cmd_pkg;
    localparam int BYTE_BITS = 8;
    localparam logic [7:0] CMD_DISPLAY_OFF    = 8'hAE;
    localparam logic [7:0] CMD_DISPLAY_ON     = 8'hAF;
    localparam logic [7:0] CMD_CONTRAST       = 8'h81;
    localparam logic [7:0] CMD_FOLLOW_RAM     = 8'hA4;
    localparam logic [7:0] CMD_ALL_ON         = 8'hA5;
    localparam logic [7:0] CMD_NORMAL         = 8'hA6;
    localparam logic [7:0] CMD_INVERT         = 8'hA7;
    localparam logic [7:0] CMD_MUX_RATIO      = 8'hA8;
    localparam logic [7:0] CMD_SEG_NORMAL     = 8'hA0;
    localparam logic [7:0] CMD_SEG_REMAP      = 8'hA1;
    localparam logic [7:0] CMD_COM_NORMAL     = 8'hC0;
    localparam logic [7:0] CMD_COM_REVERSE    = 8'hC8;
    localparam logic [7:0] START_LINE_BASE    = 8'h40;
    localparam logic [7:0] START_LINE_MASK    = 8'hC0;
    localparam logic [7:0] COL_LOW_BASE       = 8'h00;
    localparam logic [7:0] COL_HIGH_BASE      = 8'h10;
    localparam logic [7:0] NIBBLE_CMD_MASK    = 8'hF0;
    localparam logic [7:0] CONTRAST_RESET     = 8'h7F;
    localparam logic [5:0] MUX_RESET          = 6'h3F;
    localparam logic [5:0] START_LINE_RESET   = 6'h00;
    localparam logic [7:0] COLUMN_RESET       = 8'h00;
    localparam int COLUMN_COUNT = 132;
endpackage

// ==== hw/serial_byte_receiver.sv ====
// Purpose: Shifts in serial bytes on the link clock and hands each whole byte across.
// Assumes: Link clock idles between frames; select high ends a frame.
// Notes:   Byte handoff is a toggle plus held data, stable until the next byte.
`timescale 1ns/1ns
`default_nettype none
module serial_byte_receiver
    import oled_cmd_pkg::*;
(
    input  wire logic       link_clk,
    input  wire logic       select_low,
    input  wire logic       serial_data,
    input  wire logic       cmd_data_select,
    input  wire logic       panel_init_low,
    output logic            byte_toggle_q,
    output logic [7:0]      byte_value_q,
    output logic            byte_is_data_q
);
    logic [6:0] shift_q;
    logic [6:0] shift_d;
    logic [2:0] count_q;
    logic [2:0] count_d;
    logic       toggle_d;
    logic [7:0] value_d;
    logic       is_data_d;

    // Collects bits msb first; the eighth bit completes and publishes the byte.
    always_comb begin
        shift_d   = {shift_q[5:0], serial_data};
        count_d   = count_q + 3'h1;
        toggle_d  = byte_toggle_q;
        value_d   = byte_value_q;
        is_data_d = byte_is_data_q;
        if (count_q == 3'(BYTE_BITS - 1)) begin
            toggle_d  = ~byte_toggle_q;
            value_d   = {shift_q, serial_data};
            is_data_d = cmd_data_select;
            count_d   = 3'h0;
        end
    end

    // Select high or panel reset drops a partial byte at once.
    always_ff @(posedge link_clk or posedge select_low or negedge panel_init_low) begin
        if (!panel_init_low) begin
            shift_q <= 7'h00;
            count_q <= 3'h0;
        end else if (select_low) begin
            shift_q <= 7'h00;
            count_q <= 3'h0;
        end else begin
            shift_q <= shift_d;
            count_q <= count_d;
        end
    end

    // The published byte outlives the frame; only panel reset clears it.
    always_ff @(posedge link_clk or negedge panel_init_low) begin
        if (!panel_init_low) begin
            byte_toggle_q  <= 1'b0;
            byte_value_q   <= 8'h00;
            byte_is_data_q <= 1'b0;
        end else begin
            byte_toggle_q  <= toggle_d;
            byte_value_q   <= value_d;
            byte_is_data_q <= is_data_d;
        end
    end
endmodule // serial_byte_receiver
`default_nettype wire

// ==== hw/oled_serial_cmd_port.sv ====
// Purpose: Serial command port and control state of a 128x64 display controller.
// Assumes: Host frames each byte with select; link clock unrelated to core_clk.
// Notes:   Outputs are registered; display memory writes appear as a data strobe.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Panel reset: display off, 128x64 mode.
// - Reset restores non-remapped column and row mapping.
// - Reset clears partial serial shift bits.
// - Reset zeroes start line and column counter.
// - Reset selects normal row scan order.
// - Reset loads contrast with 7Fh.
// - Reset selects normal display following memory.
// - Select frames byte; command/data low means command.
// - Command/data high makes byte display data.
// - Msb first, captured on rising clock.
// - AEh turns display off, AFh on.
// - 81h takes next command as contrast.
// - A4h follows memory, A5h forces all on.
// - A6h normal pixels, A7h inverts them.
// - A8h takes next command as multiplex ratio.
// - 40h plus low bits sets start line.
module oled_serial_cmd_port
    import oled_cmd_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       link_clk,
    input  wire logic       select_low,
    input  wire logic       serial_data,
    input  wire logic       cmd_data_select,
    input  wire logic       panel_init_low,
    output logic            display_on_q,
    output logic [7:0]      contrast_q,
    output logic            entire_on_q,
    output logic            inverse_q,
    output logic [5:0]      mux_ratio_q,
    output logic [5:0]      start_line_q,
    output logic            seg_remap_q,
    output logic            com_reverse_q,
    output logic [7:0]      column_q,
    output logic            ram_write_q,
    output logic [7:0]      ram_data_q
);
    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_CONTRAST = 2'b01,
        ST_MUX      = 2'b10
    } arg_state_type;

    logic          rx_toggle;
    logic [7:0]    rx_value;
    logic          rx_is_data;
    logic [2:0]    tog_sync_q;
    logic [1:0]    init_sync_q;
    logic          init_low;
    logic          byte_evt;
    arg_state_type state_q, state_d;
    logic          display_on_d, entire_on_d, inverse_d, seg_remap_d, com_reverse_d;
    logic [7:0]    contrast_d, column_d, ram_data_d;
    logic [5:0]    mux_ratio_d, start_line_d;
    logic          ram_write_d;

    // Link-side shift register lives on the link clock.
    serial_byte_receiver u_rx (
        .link_clk        (link_clk),
        .select_low      (select_low),
        .serial_data     (serial_data),
        .cmd_data_select (cmd_data_select),
        .panel_init_low  (panel_init_low),
        .byte_toggle_q   (rx_toggle),
        .byte_value_q    (rx_value),
        .byte_is_data_q  (rx_is_data)
    );

    // Matches a command byte under a mask.
    function automatic logic cmd_match(input logic [7:0] b, input logic [7:0] mask,
                                       input logic [7:0] base);
        cmd_match = (b & mask) == base;
    endfunction

    // Toggle chain keeps running through core reset, so a byte taken before
    // reset is never replayed after it; core reset must last three cycles.
    always_ff @(posedge core_clk) begin
        tog_sync_q <= {tog_sync_q[1:0], rx_toggle};
    end

    // Reset pin passes two flops before any core_clk logic reads it; the receiver takes it directly.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            init_sync_q <= 2'h0;
        end else begin
            init_sync_q <= {init_sync_q[0], panel_init_low};
        end
    end

    assign init_low = ~init_sync_q[1];
    assign byte_evt = tog_sync_q[2] ^ tog_sync_q[1];

    // Interprets each completed byte; byte data is stable long after the toggle.
    always_comb begin
        state_d       = state_q;
        display_on_d  = display_on_q;
        contrast_d    = contrast_q;
        entire_on_d   = entire_on_q;
        inverse_d     = inverse_q;
        mux_ratio_d   = mux_ratio_q;
        start_line_d  = start_line_q;
        seg_remap_d   = seg_remap_q;
        com_reverse_d = com_reverse_q;
        column_d      = column_q;
        ram_data_d    = ram_data_q;
        ram_write_d   = 1'b0;
        if (byte_evt) begin
            if (rx_is_data) begin
                ram_write_d = 1'b1;
                ram_data_d  = rx_value;
                if (column_q == 8'(COLUMN_COUNT - 1)) begin
                    column_d = COLUMN_RESET;
                end else begin
                    column_d = column_q + 8'h01;
                end
            end else begin
                case (state_q)
                    ST_CONTRAST: begin
                        contrast_d = rx_value;
                        state_d    = ST_IDLE;
                    end
                    ST_MUX: begin
                        mux_ratio_d = rx_value[5:0];
                        state_d     = ST_IDLE;
                    end
                    default: begin
                        if (rx_value == CMD_DISPLAY_OFF) begin
                            display_on_d = 1'b0;
                        end else if (rx_value == CMD_DISPLAY_ON) begin
                            display_on_d = 1'b1;
                        end else if (rx_value == CMD_CONTRAST) begin
                            state_d = ST_CONTRAST;
                        end else if (rx_value == CMD_FOLLOW_RAM) begin
                            entire_on_d = 1'b0;
                        end else if (rx_value == CMD_ALL_ON) begin
                            entire_on_d = 1'b1;
                        end else if (rx_value == CMD_NORMAL) begin
                            inverse_d = 1'b0;
                        end else if (rx_value == CMD_INVERT) begin
                            inverse_d = 1'b1;
                        end else if (rx_value == CMD_MUX_RATIO) begin
                            state_d = ST_MUX;
                        end else if (rx_value == CMD_SEG_NORMAL) begin
                            seg_remap_d = 1'b0;
                        end else if (rx_value == CMD_SEG_REMAP) begin
                            seg_remap_d = 1'b1;
                        end else if (rx_value == CMD_COM_NORMAL) begin
                            com_reverse_d = 1'b0;
                        end else if (rx_value == CMD_COM_REVERSE) begin
                            com_reverse_d = 1'b1;
                        end else if (cmd_match(rx_value, START_LINE_MASK, START_LINE_BASE)) begin
                            start_line_d = rx_value[5:0];
                        end else if (cmd_match(rx_value, NIBBLE_CMD_MASK, COL_LOW_BASE)) begin
                            column_d = {column_q[7:4], rx_value[3:0]};
                        end else if (cmd_match(rx_value, NIBBLE_CMD_MASK, COL_HIGH_BASE)) begin
                            column_d = {rx_value[3:0], column_q[3:0]};
                        end
                    end
                endcase
            end
        end
        if (init_low) begin
            state_d       = ST_IDLE;
            display_on_d  = 1'b0;
            mux_ratio_d   = MUX_RESET;
            seg_remap_d   = 1'b0;
            com_reverse_d = 1'b0;
            start_line_d  = START_LINE_RESET;
            column_d      = COLUMN_RESET;
            contrast_d    = CONTRAST_RESET;
            entire_on_d   = 1'b0;
            inverse_d     = 1'b0;
            ram_write_d   = 1'b0;
        end
    end

    // Registers the control state; core reset gives the same defaults.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q       <= ST_IDLE;
            display_on_q  <= 1'b0;
            contrast_q    <= CONTRAST_RESET;
            entire_on_q   <= 1'b0;
            inverse_q     <= 1'b0;
            mux_ratio_q   <= MUX_RESET;
            start_line_q  <= START_LINE_RESET;
            seg_remap_q   <= 1'b0;
            com_reverse_q <= 1'b0;
            column_q      <= COLUMN_RESET;
            ram_write_q   <= 1'b0;
            ram_data_q    <= 8'h00;
        end else begin
            state_q       <= state_d;
            display_on_q  <= display_on_d;
            contrast_q    <= contrast_d;
            entire_on_q   <= entire_on_d;
            inverse_q     <= inverse_d;
            mux_ratio_q   <= mux_ratio_d;
            start_line_q  <= start_line_d;
            seg_remap_q   <= seg_remap_d;
            com_reverse_q <= com_reverse_d;
            column_q      <= column_d;
            ram_write_q   <= ram_write_d;
            ram_data_q    <= ram_data_d;
        end
    end
endmodule // oled_serial_cmd_port
`default_nettype wire

// ==== testbench/oled_port_monitor.sv ====
// Purpose: Concurrent checks on the serial command port outputs.
// Assumes: Panel reset reaches the core within three core edges.
// Notes:   Bound to the port below the module.
`timescale 1ns/1ns
`default_nettype none
module oled_port_monitor
    import oled_cmd_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       select_low,
    input wire logic       panel_init_low,
    input wire logic       display_on_q,
    input wire logic [7:0] contrast_q,
    input wire logic       entire_on_q,
    input wire logic       inverse_q,
    input wire logic [5:0] mux_ratio_q,
    input wire logic [5:0] start_line_q,
    input wire logic       seg_remap_q,
    input wire logic       com_reverse_q,
    input wire logic [7:0] column_q,
    input wire logic       ram_write_q,
    input wire logic [7:0] ram_data_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Panel reset held long enough to reach the core.
    sequence held_s; !panel_init_low [*4]; endsequence
    // Link idle and panel out of reset, so no byte can be in flight.
    sequence quiet_s; (select_low && panel_init_low) [*8]; endsequence
    panel_off_a: assert property (held_s |-> !display_on_q && mux_ratio_q == MUX_RESET)
        else $error("display not off in panel reset");
    map_reset_a: assert property (held_s |-> !seg_remap_q && !com_reverse_q)
        else $error("mapping not normal in panel reset");
    line_col_a: assert property (held_s |-> start_line_q == 6'h00 && column_q == 8'h00)
        else $error("start line or column not zero in panel reset");
    contrast_rst_a: assert property (held_s |-> contrast_q == 8'h7F)
        else $error("contrast not at default in panel reset");
    normal_mode_a: assert property (held_s |-> !entire_on_q && !inverse_q)
        else $error("display mode not normal in panel reset");
    data_pulse_a: assert property (ram_write_q |=> !ram_write_q)
        else $error("data strobe longer than one cycle");
    data_keeps_a: assert property (ram_write_q |-> $stable({display_on_q, contrast_q}))
        else $error("data byte changed a setting");
    link_quiet_a: assert property (quiet_s |-> $stable({inverse_q, column_q}) && !ram_write_q)
        else $error("output moved without a framed byte");
endmodule // oled_port_monitor
bind oled_serial_cmd_port oled_port_monitor mon (.core_clk, .reset, .select_low,
    .panel_init_low, .display_on_q, .contrast_q, .entire_on_q, .inverse_q, .mux_ratio_q,
    .start_line_q, .seg_remap_q, .com_reverse_q, .column_q, .ram_write_q, .ram_data_q);
`default_nettype wire

// ==== testbench/serial_host_model.sv ====
// Purpose: Host side of the four-wire serial link.
// Assumes: Link clock of 64 ns that idles high between frames.
// Notes:   Long host delays are scaled down to a few hundred ns.
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
    input  wire logic core_clk,
    output var logic  link_clk,
    output var logic  select_low,
    output var logic  serial_data,
    output var logic  cmd_data_select,
    output var logic  panel_init_low
);
    // Idle levels of the host lines.
    initial begin
        {link_clk, select_low, serial_data, cmd_data_select, panel_init_low} = 5'h1B;
    end
    // Shifts out the top n bits of one byte inside one frame.
    task automatic send(input logic d, input logic [7:0] v, input int n);
        @(posedge core_clk);
        #3;
        select_low = 1'b0;
        cmd_data_select = d;
        for (int i = 7; i >= 8 - n; i--) begin
            link_clk = 1'b0;
            serial_data = v[i];
            #32;
            link_clk = 1'b1;
            #32;
        end
        select_low = 1'b1;
        serial_data = ~serial_data; // Released line must not keep the last bit.
        #200;
    endtask
    // Pulses the panel reset low between two high periods.
    task automatic panel_pulse();
        @(posedge core_clk);
        #3;
        panel_init_low = 1'b0;
        #80;
        panel_init_low = 1'b1;
        #80;
    endtask
endmodule // serial_host_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench for the serial command port.
// Assumes: Each byte settles well before its frame closes.
// Notes:   Host delays of 100 ms are not modelled.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb
    import oled_cmd_pkg::*;
;
    logic core_clk, reset, link_clk, select_low, serial_data, cmd_data_select, panel_init_low;
    logic display_on_q, entire_on_q, inverse_q, seg_remap_q, com_reverse_q, ram_write_q;
    logic [7:0] contrast_q, column_q, ram_data_q;
    logic [5:0] mux_ratio_q, start_line_q;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int writes = 0;
    serial_host_model host (.core_clk, .link_clk, .select_low, .serial_data,
        .cmd_data_select, .panel_init_low);
    oled_serial_cmd_port dut (.core_clk, .reset, .link_clk, .select_low, .serial_data,
        .cmd_data_select, .panel_init_low, .display_on_q, .contrast_q, .entire_on_q,
        .inverse_q, .mux_ratio_q, .start_line_q, .seg_remap_q, .com_reverse_q, .column_q,
        .ram_write_q, .ram_data_q);
    // Core clock of 8 ns.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Cuts a hung run short.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            stop_test();
        end
    end
    // Counts display data strobes seen at the core clock.
    always @(posedge core_clk) begin
        if (ram_write_q === 1'b1) begin
            writes++;
        end
    end
    task automatic cmd(input logic [7:0] v);
        host.send(1'b0, v, 8);
    endtask
    task automatic check_defaults();
        `CHK({display_on_q, mux_ratio_q}, {1'b0, MUX_RESET})
        `CHK({seg_remap_q, com_reverse_q}, 2'b00)
        `CHK({start_line_q, column_q}, 14'h0000)
        `CHK(contrast_q, 8'h7F)
        `CHK({entire_on_q, inverse_q}, 2'b00)
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence: power-up setup, every command, faults, resets, column wrap.
    initial begin
        reset = 1'b1;
        // The panel reset pulse clears the link-side receiver before first use.
        fork
            host.panel_pulse();
            begin
                repeat (8) @(posedge core_clk);
                #3 reset = 1'b0;
                check_defaults();
            end
        join
        cmd(CMD_DISPLAY_OFF);
        `CHK(display_on_q, 1'b0)
        cmd(8'h45);
        `CHK(start_line_q, 6'h05)
        cmd(CMD_CONTRAST);
        host.send(1'b1, 8'hC4, 8);
        `CHK({ram_data_q, column_q}, 16'hC401)
        cmd(8'h3C);
        `CHK(contrast_q, 8'h3C)
        cmd(CMD_MUX_RATIO);
        cmd(8'h1F);
        `CHK(mux_ratio_q, 6'h1F)
        cmd(CMD_ALL_ON);
        `CHK(entire_on_q, 1'b1)
        cmd(CMD_FOLLOW_RAM);
        `CHK(entire_on_q, 1'b0)
        cmd(CMD_INVERT);
        `CHK(inverse_q, 1'b1)
        cmd(CMD_NORMAL);
        `CHK(inverse_q, 1'b0)
        cmd(CMD_SEG_REMAP);
        cmd(CMD_COM_REVERSE);
        `CHK({seg_remap_q, com_reverse_q}, 2'b11)
        cmd(CMD_SEG_NORMAL);
        `CHK({seg_remap_q, com_reverse_q}, 2'b01)
        // Panel supply settle time before display-on, scaled down.
        repeat (50) @(posedge core_clk);
        cmd(CMD_DISPLAY_ON);
        `CHK(display_on_q, 1'b1)
        host.send(1'b0, CMD_DISPLAY_OFF, 5);
        cmd(CMD_INVERT);
        `CHK({display_on_q, inverse_q}, 2'b11)
        // Panel reset as a frame opens must drop the bit clocked during it, so the byte never completes.
        fork
            cmd(CMD_DISPLAY_ON);
            host.panel_pulse();
        join
        check_defaults();
        cmd(CMD_SEG_REMAP);
        cmd(CMD_COM_REVERSE);
        cmd(CMD_COM_NORMAL);
        `CHK({seg_remap_q, com_reverse_q}, 2'b10)
        cmd(CMD_INVERT);
        @(posedge core_clk);
        #3 reset = 1'b1;
        repeat (4) @(posedge core_clk);
        #3 reset = 1'b0;
        check_defaults();
        repeat (COLUMN_COUNT + 1) host.send(1'b1, 8'h5A, 8);
        `CHK(column_q, 8'h01)
        cmd(COL_HIGH_BASE | 8'h02);
        cmd(COL_LOW_BASE | 8'h05);
        `CHK(column_q, 8'h25)
        `CHK(writes, COLUMN_COUNT + 2)
        cmd(CMD_DISPLAY_ON);
        `CHK(display_on_q, 1'b1)
        // Power-down: display off first, then the panel discharge wait, scaled down.
        cmd(CMD_DISPLAY_OFF);
        `CHK(display_on_q, 1'b0)
        repeat (50) @(posedge core_clk);
        stop_test();
    end
endmodule // tb
`default_nettype wire
